/* File: bench/port_pin_function_mux_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module port_pin_function_mux_tb;
	logic i_clk;
	logic i_rst = 1'b1;
	logic i_serial0_transmit = '0, i_serial1_transmit = '0, i_clock_output_pin = '0;
	logic i_muxed_addr_data_oe = '0, i_address_latch = '0, i_instruction_fetch_flag = '0;
	logic i_write_low_strobe_n = '0, i_read_strobe_n = '0, i_bus_request_out_n = '0;
	logic i_high_byte_write_n = '0, i_sync_serial0_clock = '0, i_sync_serial0_clock_oe = '0;
	logic i_sync_serial0_data = '0, i_sync_serial0_data_oe = '0, i_sync_serial1_clock = '0;
	logic i_sync_serial1_clock_oe = '0, i_sync_serial1_data = '0, i_sync_serial1_data_oe = '0;
	logic i_capture_compare_ch16 = '0, i_capture_compare_ch16_oe = '0;
	logic [7:0] i_p2_sel = '0, i_p2_data = '0, i_p2_dir = '0, i_p3_sel = '0, i_p3_data = '0;
	logic [7:0] i_p3_dir = '0, i_p3_od = '0, i_p4_sel = '0, i_p4_data = '0, i_p4_dir = '0;
	logic [7:0] i_p4_od = '0, i_p4_pad_in = '0, i_p5_sel = '0, i_p5_data = '0, i_p5_dir = '0;
	logic [7:0] i_p7_sel = '0, i_p7_data = '0, i_p7_dir = '0, i_p7_pad_in = '0, i_p8_sel = '0;
	logic [7:0] i_p8_data = '0, i_p8_dir = '0, i_p8_pad_in = '0, i_p9_sel = '0, i_p9_data = '0;
	logic [7:0] i_p9_dir = '1, i_p9_pad_in = '0, i_compare_only_outputs = '0;
	logic [7:0] i_muxed_addr_data_low = '0, i_muxed_addr_data_high = '0;
	logic [7:0] pull2 = '1, pull3 = '1, pull5 = '1, i_p2_pad_in, i_p3_pad_in, i_p5_pad_in;
	logic [5:0] i_p10_sel = '0, i_p10_data = '0, i_p10_dir = '0, i_p10_pad_in = '0;
	logic [15:0] i_capture_compare_channels = '0, i_capture_compare_oe = '0;
	logic [7:0] o_p2_pad_out, o_p2_pad_oe, o_p2_in, o_p3_pad_out, o_p3_pad_oe, o_p3_in;
	logic [7:0] o_p4_pad_out, o_p4_pad_oe, o_p4_in, o_p5_pad_out, o_p5_pad_oe, o_p5_in;
	logic [7:0] o_p7_pad_out, o_p7_pad_oe, o_p7_in, o_p8_pad_out, o_p8_pad_oe, o_p8_in;
	logic [7:0] o_p9_pad_out, o_p9_pad_oe, o_p9_in;
	logic [5:0] o_p10_pad_out, o_p10_pad_oe, o_p10_in;
	logic [15:0] o_capture_compare_channels;
	logic [3:0] o_timer_clock_in, o_timer_reset_in;
	logic o_serial0_receive, o_serial1_receive, o_external_interrupt_in, o_ready_in;
	logic o_powerdown_recovery_pin, o_sync_serial0_clock, o_sync_serial0_data;
	logic o_sync_serial1_clock, o_sync_serial1_data, o_capture_compare_ch16;
	logic o_test_mode, o_emulation_mode;
	int failures = 0;
	int check_count = 0;
	ppfm_top dut_u (.*);
	ppfm_board b2_u (.i_out(o_p2_pad_out), .i_oe(o_p2_pad_oe), .i_pull(pull2), .o_pad(i_p2_pad_in));
	ppfm_board b3_u (.i_out(o_p3_pad_out), .i_oe(o_p3_pad_oe), .i_pull(pull3), .o_pad(i_p3_pad_in));
	ppfm_board b5_u (.i_out(o_p5_pad_out), .i_oe(o_p5_pad_oe), .i_pull(pull5), .o_pad(i_p5_pad_in));
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	task automatic stop_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	// straps are set while pads float, held over the five reset cycles
	task automatic do_reset(input logic emu_pin, input logic test_pin);
		@(posedge i_clk);
		i_rst <= 1'b1;
		pull2[6] <= emu_pin;
		pull5[4] <= test_pin;
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		settle(1);
	endtask
	task automatic t_reset;
		do_reset(1'b1, 1'b1);
		chk({o_emulation_mode, o_test_mode}, 2'b00);
		chk(o_p9_pad_oe, 8'h00);
		$display("t_reset done");
	endtask
	task automatic t_port;
		@(posedge i_clk);
		{i_p2_data, i_p4_data, i_p5_data, i_p7_data, i_p8_data, i_p9_data} <= 48'ha5c3_3c5a_0ff0;
		{i_p2_dir, i_p4_dir, i_p5_dir, i_p7_dir, i_p8_dir, i_p9_dir} <= 48'hffff_ffff_ffff;
		i_p10_data <= 6'h2a;
		i_p10_dir <= 6'h0f;
		settle(1);
		chk({o_p2_pad_out, o_p4_pad_out, o_p5_pad_out, o_p7_pad_out, o_p8_pad_out, o_p9_pad_out},
			48'ha5c3_3c5a_0ff0);
		chk({o_p2_pad_oe, o_p4_pad_oe, o_p5_pad_oe, o_p7_pad_oe, o_p8_pad_oe, o_p9_pad_oe},
			48'hffff_ffff_ffff);
		chk({o_p10_pad_out, o_p10_pad_oe}, 12'hA8F);
		$display("t_port done");
	endtask
	task automatic t_open;
		@(posedge i_clk);
		i_p3_od <= 8'hff;
		i_p3_data <= 8'h0f;
		i_p3_dir <= 8'hff;
		settle(1);
		chk({o_p3_pad_out, o_p3_pad_oe}, 16'h00f0);
		settle(2);
		chk(o_p3_in, 8'h0f);
		@(posedge i_clk);
		i_p3_sel <= 8'hff;
		{i_p4_sel, i_p4_od} <= 16'hffff;
		i_muxed_addr_data_low <= 8'h5a;
		i_muxed_addr_data_high <= 8'hc3;
		i_muxed_addr_data_oe <= 1'b1;
		settle(1);
		chk({o_p3_pad_out, o_p3_pad_oe, o_p4_pad_out, o_p4_pad_oe}, 32'h5aff_c3ff);
		$display("t_open done");
	endtask
	task automatic t_func;
		@(posedge i_clk);
		{i_p2_sel, i_p5_sel, i_p7_sel, i_p8_sel, i_p9_sel} <= 40'hff_ffff_ffff;
		i_p10_sel <= 6'h3f;
		{i_serial0_transmit, i_serial1_transmit, i_clock_output_pin} <= 3'b101;
		{i_high_byte_write_n, i_bus_request_out_n, i_read_strobe_n, i_write_low_strobe_n,
			i_instruction_fetch_flag, i_address_latch} <= 6'h2b;
		i_capture_compare_channels <= 16'h6996;
		i_capture_compare_oe <= 16'hfff0;
		i_compare_only_outputs <= 8'h5a;
		{i_capture_compare_ch16, i_sync_serial1_data, i_sync_serial1_clock, i_sync_serial0_data,
			i_sync_serial0_clock} <= 5'h1d;
		{i_capture_compare_ch16_oe, i_sync_serial1_data_oe, i_sync_serial1_clock_oe,
			i_sync_serial0_data_oe, i_sync_serial0_clock_oe} <= 5'h1d;
		settle(1);
		chk({o_p2_pad_out & 8'h89, o_p2_pad_oe}, 16'h8189);
		chk({o_p5_pad_oe, 2'b00, o_p5_pad_out[5:0]}, 16'h3f2b);
		chk({o_p7_pad_out, o_p8_pad_out, o_p7_pad_oe, o_p8_pad_oe}, 32'h9669_f0ff);
		chk({o_p9_pad_out, o_p9_pad_oe}, 16'h5aff);
		chk({2'b00, o_p10_pad_oe, 3'b000, o_p10_pad_out[4:0]}, 16'h1d1d);
		$display("t_func done");
	endtask
	task automatic t_in;
		@(posedge i_clk);
		pull2 <= 8'hc2;
		pull5 <= 8'h50;
		i_p7_pad_in <= 8'h93;
		i_p8_pad_in <= 8'hc4;
		i_p10_pad_in <= 6'h15;
		i_p9_pad_in <= 8'h3c;
		i_p4_pad_in <= 8'h81;
		settle(2);
		chk({o_timer_reset_in, o_timer_clock_in}, 8'h95);
		chk(o_capture_compare_channels, 16'hc493);
		chk({o_p9_in, o_p4_in}, 16'h3c81);
		chk({o_capture_compare_ch16, o_sync_serial1_data, o_sync_serial1_clock,
			o_sync_serial0_data, o_sync_serial0_clock}, 5'h15);
		chk({o_serial1_receive, o_external_interrupt_in, o_serial0_receive}, 3'b001);
		chk({o_powerdown_recovery_pin, o_ready_in}, 2'b01);
		$display("t_in done");
	endtask
	task automatic t_strap;
		do_reset(1'b1, 1'b0);
		chk({o_emulation_mode, o_test_mode}, 2'b01);
		do_reset(1'b0, 1'b1);
		chk({o_emulation_mode, o_test_mode}, 2'b10);
		settle(2);
		chk({o_p2_pad_oe, o_p3_pad_oe, o_p9_pad_oe}, 24'h00_0000);
		do_reset(1'b1, 1'b1);
		chk({o_emulation_mode, o_test_mode}, 2'b00);
		settle(1);
		chk(o_p9_pad_oe, 8'hff);
		$display("t_strap done");
	endtask
	initial begin
		t_reset;
		t_port;
		t_open;
		t_func;
		t_in;
		t_strap;
		stop_test;
	end
	initial begin
		#(50 * 2000);
		failures++;
		stop_test;
	end
endmodule
`default_nettype wire

/* File: bench/ppfm_board.sv */
`timescale 1ns/1ps
`default_nettype none
module ppfm_board #(
	parameter int W = 8
) (
	input wire logic [W-1:0] i_out,
	input wire logic [W-1:0] i_oe,
	input wire logic [W-1:0] i_pull,
	output logic [W-1:0] o_pad
);
	// straps rest high unless a test pulls low
	assign o_pad = (i_oe & i_out) | (~i_oe & i_pull);
endmodule
`default_nettype wire

/* File: bench/ppfm_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module ppfm_top_assertions (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_muxed_addr_data_oe,
	input wire logic o_test_mode,
	input wire logic o_emulation_mode,
	input wire logic [3:0] o_timer_clock_in,
	input wire logic [15:0] o_capture_compare_channels,
	input wire logic [7:0] i_p2_sel, o_p2_pad_oe, o_p2_in, i_p3_sel, i_p3_od, i_p3_data,
	input wire logic [7:0] i_p3_dir, o_p3_pad_out, o_p3_pad_oe, i_p4_sel, o_p4_pad_out,
	input wire logic [7:0] i_muxed_addr_data_low, i_muxed_addr_data_high, o_p5_in, o_p7_in,
	input wire logic [7:0] o_p8_in, o_p9_pad_oe, i_p7_pad_in, i_p8_pad_in
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	// pads stay released for the edge after release
	AST_RST_FLOAT: assert property ($fell(i_rst) |-> o_p2_pad_oe == 8'h00 ##1 o_p3_pad_oe == 8'h00)
		else $error("pads driven right after reset");
	AST_TEST_STRAP: assert property ($fell(i_rst) |=> o_test_mode == !$past(o_p5_in[4]))
		else $error("test strap latched wrong");
	AST_EMU_STRAP: assert property ($fell(i_rst) |=> o_emulation_mode == !$past(o_p2_in[6]))
		else $error("emulation strap latched wrong");
	AST_STRAP_HOLD: assert property (!$fell(i_rst) |=> $stable(o_test_mode) && $stable(o_emulation_mode))
		else $error("strap flags moved outside reset");
	// pads float from the first cycle the flag shows
	AST_EMU_FLOAT: assert property (o_emulation_mode
		|-> (o_p2_pad_oe | o_p3_pad_oe | o_p9_pad_oe) == 8'h00)
		else $error("pad driven in emulation mode");
	AST_AD_PUSHPULL: assert property (i_p3_sel == 8'hff && i_p3_od == 8'hff
		&& i_muxed_addr_data_oe && !o_emulation_mode && !$past(i_rst)
		|=> o_p3_pad_oe == 8'hff && o_p3_pad_out == $past(i_muxed_addr_data_low))
		else $error("address/data low byte not push-pull");
	AST_OPEN_DRAIN: assert property (i_p3_sel == 8'h00 && i_p3_od == 8'hff
		&& !o_emulation_mode && !$past(i_rst)
		|=> o_p3_pad_out == 8'h00 && o_p3_pad_oe == ($past(i_p3_dir) & ~$past(i_p3_data)))
		else $error("open-drain drive wrong");
	AST_HIGH_BYTE: assert property (i_p4_sel == 8'hff && i_muxed_addr_data_oe
		&& !$past(i_rst)
		|=> o_p4_pad_out == $past(i_muxed_addr_data_high))
		else $error("high address/data byte wrong");
	AST_P2_FUNC_OE: assert property (i_p2_sel == 8'hff && !o_emulation_mode
		&& !$past(i_rst)
		|=> o_p2_pad_oe == 8'h89)
		else $error("port 2 function enables wrong");
	AST_CC_MAP: assert property (o_capture_compare_channels == {o_p8_in, o_p7_in}
		&& {o_p8_in, o_p7_in} == $past({i_p8_pad_in, i_p7_pad_in}, 2)
		&& o_timer_clock_in == {o_p7_in[6], o_p7_in[4], o_p7_in[2], o_p7_in[0]})
		else $error("capture/compare input map wrong");
	cover property ($fell(i_rst) ##1 o_emulation_mode);
	cover property ($fell(i_rst) ##1 o_test_mode);
	cover property (i_p3_sel == 8'hff && i_muxed_addr_data_oe);
endmodule
bind ppfm_top ppfm_top_assertions chk_u (.*);
`default_nettype wire

/* File: rtl/ppfm_map.svh */
`ifndef PPFM_MAP_SVH
`define PPFM_MAP_SVH
// port widths
`define PPFM_W8 8
`define PPFM_W6 6
// port 2 bit positions
`define PPFM_P2_SER0_TX 0
`define PPFM_P2_SER0_RX 1
`define PPFM_P2_EXTERNAL_INTERRUPT_IN 2
`define PPFM_P2_SER1_TX 3
`define PPFM_P2_SER1_RX 4
`define PPFM_P2_EMU_STRAP 6
`define PPFM_P2_CLOCK_OUTPUT_PIN 7
// port 2 bits whose special function drives the pad
`define PPFM_P2_FUNC_OE 8'h89
// port 5 bit positions
`define PPFM_P5_ALE 0
`define PPFM_P5_INSTRUCTION_FETCH_FLAG 1
`define PPFM_P5_WRL 2
`define PPFM_P5_RD 3
`define PPFM_P5_BUS_REQUEST_OUT_N 4
`define PPFM_P5_TEST_STRAP 4
`define PPFM_P5_BHE 5
`define PPFM_P5_READY 6
`define PPFM_P5_RPD 7
`define PPFM_P5_FUNC_OE 8'h3f
// port 10 bit positions
`define PPFM_P10_SC0 0
`define PPFM_P10_SD0 1
`define PPFM_P10_SC1 2
`define PPFM_P10_SD1 3
`define PPFM_P10_CC16 4
// capture/compare split between ports 7 and 8
`define PPFM_CC_P7_LO 0
`define PPFM_CC_P7_HI 7
`define PPFM_CC_P8_LO 8
`define PPFM_CC_P8_HI 15
`define PPFM_TMR_N 4
`endif

/* File: rtl/ppfm_pkg.sv */
`default_nettype none
package ppfm_pkg;
	typedef enum logic [1:0] {
		PPFM_IN_RESET = 2'b00,
		PPFM_NORMAL = 2'b01
	} ppfm_phase_t;
	typedef struct packed {
		ppfm_phase_t phase;
		logic test_mode;
		logic emul_mode;
	} ppfm_top_state_t;
endpackage
`default_nettype wire

/* File: rtl/ppfm_port_cell.sv */
`timescale 1ns/1ps
`default_nettype none
module ppfm_port_cell
	import ppfm_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_sel,
	input wire logic [W-1:0] i_port_data,
	input wire logic [W-1:0] i_port_dir,
	input wire logic [W-1:0] i_port_od,
	input wire logic [W-1:0] i_func_out,
	input wire logic [W-1:0] i_func_oe,
	input wire logic i_float,
	input wire logic [W-1:0] i_pad_in,
	output logic [W-1:0] o_pad_out,
	output logic [W-1:0] o_pad_oe,
	output logic [W-1:0] o_pad_in_sync
);
	typedef struct packed {
		logic [W-1:0] sel;
		logic [W-1:0] out;
		logic [W-1:0] oe;
		logic [W-1:0] sync1;
		logic [W-1:0] sync2;
	} ppfm_cell_state_t;

	ppfm_cell_state_t state;
	ppfm_cell_state_t next_state;

	always_comb begin
		next_state = state;
		// pad input always sampled, even in reset, so straps can be read
		next_state.sync1 = i_pad_in;
		next_state.sync2 = state.sync1;
		next_state.sel = i_sel;
		// special functions push-pull, open-drain applies to port logic only
		next_state.out = (i_sel & i_func_out) | (~i_sel & ~i_port_od & i_port_data);
		next_state.oe = (i_sel & i_func_oe) | (~i_sel & i_port_dir & (~i_port_od | ~i_port_data));
		if (i_float) begin
			next_state.oe = '0;
		end
		// port logic default, pads float through reset
		if (i_rst) begin
			next_state.sel = '0;
			next_state.out = '0;
			next_state.oe = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		state <= next_state;
	end

	assign o_pad_out = state.out;
	assign o_pad_oe = state.oe;
	assign o_pad_in_sync = state.sync2;
endmodule
`default_nettype wire

/* File: rtl/ppfm_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ppfm_map.svh"
module ppfm_top
	import ppfm_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	// port 2
	input wire logic [`PPFM_W8-1:0] i_p2_sel,
	input wire logic [`PPFM_W8-1:0] i_p2_data,
	input wire logic [`PPFM_W8-1:0] i_p2_dir,
	input wire logic [`PPFM_W8-1:0] i_p2_pad_in,
	output logic [`PPFM_W8-1:0] o_p2_pad_out,
	output logic [`PPFM_W8-1:0] o_p2_pad_oe,
	output logic [`PPFM_W8-1:0] o_p2_in,
	input wire logic i_serial0_transmit,
	input wire logic i_serial1_transmit,
	input wire logic i_clock_output_pin,
	output logic o_serial0_receive,
	output logic o_serial1_receive,
	output logic o_external_interrupt_in,
	// ports 3 and 4
	input wire logic [`PPFM_W8-1:0] i_p3_sel,
	input wire logic [`PPFM_W8-1:0] i_p3_data,
	input wire logic [`PPFM_W8-1:0] i_p3_dir,
	input wire logic [`PPFM_W8-1:0] i_p3_od,
	input wire logic [`PPFM_W8-1:0] i_p3_pad_in,
	output logic [`PPFM_W8-1:0] o_p3_pad_out,
	output logic [`PPFM_W8-1:0] o_p3_pad_oe,
	output logic [`PPFM_W8-1:0] o_p3_in,
	input wire logic [`PPFM_W8-1:0] i_p4_sel,
	input wire logic [`PPFM_W8-1:0] i_p4_data,
	input wire logic [`PPFM_W8-1:0] i_p4_dir,
	input wire logic [`PPFM_W8-1:0] i_p4_od,
	input wire logic [`PPFM_W8-1:0] i_p4_pad_in,
	output logic [`PPFM_W8-1:0] o_p4_pad_out,
	output logic [`PPFM_W8-1:0] o_p4_pad_oe,
	output logic [`PPFM_W8-1:0] o_p4_in,
	input wire logic [`PPFM_W8-1:0] i_muxed_addr_data_low,
	input wire logic [`PPFM_W8-1:0] i_muxed_addr_data_high,
	input wire logic i_muxed_addr_data_oe,
	// port 5
	input wire logic [`PPFM_W8-1:0] i_p5_sel,
	input wire logic [`PPFM_W8-1:0] i_p5_data,
	input wire logic [`PPFM_W8-1:0] i_p5_dir,
	input wire logic [`PPFM_W8-1:0] i_p5_pad_in,
	output logic [`PPFM_W8-1:0] o_p5_pad_out,
	output logic [`PPFM_W8-1:0] o_p5_pad_oe,
	output logic [`PPFM_W8-1:0] o_p5_in,
	input wire logic i_address_latch,
	input wire logic i_instruction_fetch_flag,
	input wire logic i_write_low_strobe_n,
	input wire logic i_read_strobe_n,
	input wire logic i_bus_request_out_n,
	input wire logic i_high_byte_write_n,
	output logic o_ready_in,
	output logic o_powerdown_recovery_pin,
	// ports 7 and 8
	input wire logic [`PPFM_W8-1:0] i_p7_sel,
	input wire logic [`PPFM_W8-1:0] i_p7_data,
	input wire logic [`PPFM_W8-1:0] i_p7_dir,
	input wire logic [`PPFM_W8-1:0] i_p7_pad_in,
	output logic [`PPFM_W8-1:0] o_p7_pad_out,
	output logic [`PPFM_W8-1:0] o_p7_pad_oe,
	output logic [`PPFM_W8-1:0] o_p7_in,
	input wire logic [`PPFM_W8-1:0] i_p8_sel,
	input wire logic [`PPFM_W8-1:0] i_p8_data,
	input wire logic [`PPFM_W8-1:0] i_p8_dir,
	input wire logic [`PPFM_W8-1:0] i_p8_pad_in,
	output logic [`PPFM_W8-1:0] o_p8_pad_out,
	output logic [`PPFM_W8-1:0] o_p8_pad_oe,
	output logic [`PPFM_W8-1:0] o_p8_in,
	input wire logic [2*`PPFM_W8-1:0] i_capture_compare_channels,
	input wire logic [2*`PPFM_W8-1:0] i_capture_compare_oe,
	output logic [2*`PPFM_W8-1:0] o_capture_compare_channels,
	output logic [`PPFM_TMR_N-1:0] o_timer_clock_in,
	output logic [`PPFM_TMR_N-1:0] o_timer_reset_in,
	// port 9
	input wire logic [`PPFM_W8-1:0] i_p9_sel,
	input wire logic [`PPFM_W8-1:0] i_p9_data,
	input wire logic [`PPFM_W8-1:0] i_p9_dir,
	input wire logic [`PPFM_W8-1:0] i_p9_pad_in,
	output logic [`PPFM_W8-1:0] o_p9_pad_out,
	output logic [`PPFM_W8-1:0] o_p9_pad_oe,
	output logic [`PPFM_W8-1:0] o_p9_in,
	input wire logic [`PPFM_W8-1:0] i_compare_only_outputs,
	// port 10
	input wire logic [`PPFM_W6-1:0] i_p10_sel,
	input wire logic [`PPFM_W6-1:0] i_p10_data,
	input wire logic [`PPFM_W6-1:0] i_p10_dir,
	input wire logic [`PPFM_W6-1:0] i_p10_pad_in,
	output logic [`PPFM_W6-1:0] o_p10_pad_out,
	output logic [`PPFM_W6-1:0] o_p10_pad_oe,
	output logic [`PPFM_W6-1:0] o_p10_in,
	input wire logic i_sync_serial0_clock,
	input wire logic i_sync_serial0_clock_oe,
	input wire logic i_sync_serial0_data,
	input wire logic i_sync_serial0_data_oe,
	input wire logic i_sync_serial1_clock,
	input wire logic i_sync_serial1_clock_oe,
	input wire logic i_sync_serial1_data,
	input wire logic i_sync_serial1_data_oe,
	input wire logic i_capture_compare_ch16,
	input wire logic i_capture_compare_ch16_oe,
	output logic o_sync_serial0_clock,
	output logic o_sync_serial0_data,
	output logic o_sync_serial1_clock,
	output logic o_sync_serial1_data,
	output logic o_capture_compare_ch16,
	// strap results
	output logic o_test_mode,
	output logic o_emulation_mode
);
	ppfm_top_state_t state;
	ppfm_top_state_t next_state;
	logic [`PPFM_W8-1:0] p2_func;
	logic [`PPFM_W8-1:0] p5_func;
	logic [`PPFM_W6-1:0] p10_func;
	logic [`PPFM_W6-1:0] p10_func_oe;
	logic [`PPFM_W8-1:0] all_ones;
	logic [`PPFM_W8-1:0] all_zero;
	logic [`PPFM_W6-1:0] zero6;
	logic cell_hold;

	assign all_ones = 8'hff;
	assign all_zero = 8'h00;
	assign zero6 = 6'h00;
	// pads stay released on the edge where the straps land, so no one-cycle glitch
	assign cell_hold = i_rst | (state.phase == PPFM_IN_RESET);

	always_comb begin
		p2_func = 8'h00;
		p2_func[`PPFM_P2_SER0_TX] = i_serial0_transmit;
		p2_func[`PPFM_P2_SER1_TX] = i_serial1_transmit;
		p2_func[`PPFM_P2_CLOCK_OUTPUT_PIN] = i_clock_output_pin;
	end

	always_comb begin
		p5_func = 8'h00;
		p5_func[`PPFM_P5_ALE] = i_address_latch;
		p5_func[`PPFM_P5_INSTRUCTION_FETCH_FLAG] = i_instruction_fetch_flag;
		p5_func[`PPFM_P5_WRL] = i_write_low_strobe_n;
		p5_func[`PPFM_P5_RD] = i_read_strobe_n;
		p5_func[`PPFM_P5_BUS_REQUEST_OUT_N] = i_bus_request_out_n;
		p5_func[`PPFM_P5_BHE] = i_high_byte_write_n;
	end

	// sync serial and channel 16 on port 10, bit 5 plain I/O
	always_comb begin
		p10_func = 6'h00;
		p10_func_oe = 6'h00;
		p10_func[`PPFM_P10_SC0] = i_sync_serial0_clock;
		p10_func[`PPFM_P10_SD0] = i_sync_serial0_data;
		p10_func[`PPFM_P10_SC1] = i_sync_serial1_clock;
		p10_func[`PPFM_P10_SD1] = i_sync_serial1_data;
		p10_func[`PPFM_P10_CC16] = i_capture_compare_ch16;
		p10_func_oe[`PPFM_P10_SC0] = i_sync_serial0_clock_oe;
		p10_func_oe[`PPFM_P10_SD0] = i_sync_serial0_data_oe;
		p10_func_oe[`PPFM_P10_SC1] = i_sync_serial1_clock_oe;
		p10_func_oe[`PPFM_P10_SD1] = i_sync_serial1_data_oe;
		p10_func_oe[`PPFM_P10_CC16] = i_capture_compare_ch16_oe;
	end

	// straps read only after two sync flops inside the cells
	always_comb begin
		next_state = state;
		if (i_rst) begin
			next_state.phase = PPFM_IN_RESET;
			next_state.test_mode = 1'b0;
			next_state.emul_mode = 1'b0;
		end else begin
			case (state.phase)
				PPFM_IN_RESET: begin
					next_state.phase = PPFM_NORMAL;
					// test strap low selects test mode
					next_state.test_mode = ~o_p5_in[`PPFM_P5_TEST_STRAP];
					next_state.emul_mode = ~o_p2_in[`PPFM_P2_EMU_STRAP];
				end
				PPFM_NORMAL: begin
					next_state.phase = PPFM_NORMAL;
				end
				default: begin
					next_state.phase = PPFM_IN_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		state <= next_state;
	end

	assign o_test_mode = state.test_mode;
	assign o_emulation_mode = state.emul_mode;

	ppfm_port_cell #(.W(`PPFM_W8)) u_p2 (
		.i_clk(i_clk), .i_rst(cell_hold), .i_sel(i_p2_sel), .i_port_data(i_p2_data),
		.i_port_dir(i_p2_dir), .i_port_od(all_zero), .i_func_out(p2_func),
		.i_func_oe(`PPFM_P2_FUNC_OE), .i_float(state.emul_mode), .i_pad_in(i_p2_pad_in),
		.o_pad_out(o_p2_pad_out), .o_pad_oe(o_p2_pad_oe), .o_pad_in_sync(o_p2_in)
	);
	assign o_serial0_receive = o_p2_in[`PPFM_P2_SER0_RX];
	assign o_serial1_receive = o_p2_in[`PPFM_P2_SER1_RX];
	assign o_external_interrupt_in = o_p2_in[`PPFM_P2_EXTERNAL_INTERRUPT_IN];

	// address/data low byte, open-drain only for port use
	ppfm_port_cell #(.W(`PPFM_W8)) u_p3 (
		.i_clk(i_clk), .i_rst(cell_hold), .i_sel(i_p3_sel), .i_port_data(i_p3_data),
		.i_port_dir(i_p3_dir), .i_port_od(i_p3_od), .i_func_out(i_muxed_addr_data_low),
		.i_func_oe({`PPFM_W8{i_muxed_addr_data_oe}}), .i_float(state.emul_mode),
		.i_pad_in(i_p3_pad_in), .o_pad_out(o_p3_pad_out), .o_pad_oe(o_p3_pad_oe),
		.o_pad_in_sync(o_p3_in)
	);
	ppfm_port_cell #(.W(`PPFM_W8)) u_p4 (
		.i_clk(i_clk), .i_rst(cell_hold), .i_sel(i_p4_sel), .i_port_data(i_p4_data),
		.i_port_dir(i_p4_dir), .i_port_od(i_p4_od), .i_func_out(i_muxed_addr_data_high),
		.i_func_oe({`PPFM_W8{i_muxed_addr_data_oe}}), .i_float(state.emul_mode),
		.i_pad_in(i_p4_pad_in), .o_pad_out(o_p4_pad_out), .o_pad_oe(o_p4_pad_oe),
		.o_pad_in_sync(o_p4_in)
	);

	ppfm_port_cell #(.W(`PPFM_W8)) u_p5 (
		.i_clk(i_clk), .i_rst(cell_hold), .i_sel(i_p5_sel), .i_port_data(i_p5_data),
		.i_port_dir(i_p5_dir), .i_port_od(all_zero), .i_func_out(p5_func),
		.i_func_oe(`PPFM_P5_FUNC_OE), .i_float(state.emul_mode), .i_pad_in(i_p5_pad_in),
		.o_pad_out(o_p5_pad_out), .o_pad_oe(o_p5_pad_oe), .o_pad_in_sync(o_p5_in)
	);
	assign o_ready_in = o_p5_in[`PPFM_P5_READY];
	assign o_powerdown_recovery_pin = o_p5_in[`PPFM_P5_RPD];

	ppfm_port_cell #(.W(`PPFM_W8)) u_p7 (
		.i_clk(i_clk), .i_rst(cell_hold), .i_sel(i_p7_sel), .i_port_data(i_p7_data),
		.i_port_dir(i_p7_dir), .i_port_od(all_zero),
		.i_func_out(i_capture_compare_channels[`PPFM_CC_P7_HI:`PPFM_CC_P7_LO]),
		.i_func_oe(i_capture_compare_oe[`PPFM_CC_P7_HI:`PPFM_CC_P7_LO]),
		.i_float(state.emul_mode), .i_pad_in(i_p7_pad_in), .o_pad_out(o_p7_pad_out),
		.o_pad_oe(o_p7_pad_oe), .o_pad_in_sync(o_p7_in)
	);
	// even bits timer clocks, odd bits timer resets
	genvar t;
	generate
		for (t = 0; t < `PPFM_TMR_N; t++) begin : g_tmr
			assign o_timer_clock_in[t] = o_p7_in[2*t];
			assign o_timer_reset_in[t] = o_p7_in[2*t+1];
		end
	endgenerate

	ppfm_port_cell #(.W(`PPFM_W8)) u_p8 (
		.i_clk(i_clk), .i_rst(cell_hold), .i_sel(i_p8_sel), .i_port_data(i_p8_data),
		.i_port_dir(i_p8_dir), .i_port_od(all_zero),
		.i_func_out(i_capture_compare_channels[`PPFM_CC_P8_HI:`PPFM_CC_P8_LO]),
		.i_func_oe(i_capture_compare_oe[`PPFM_CC_P8_HI:`PPFM_CC_P8_LO]),
		.i_float(state.emul_mode), .i_pad_in(i_p8_pad_in), .o_pad_out(o_p8_pad_out),
		.o_pad_oe(o_p8_pad_oe), .o_pad_in_sync(o_p8_in)
	);
	assign o_capture_compare_channels = {o_p8_in, o_p7_in};

	// compare-only outputs drive when selected, except in reset and emulation mode
	ppfm_port_cell #(.W(`PPFM_W8)) u_p9 (
		.i_clk(i_clk), .i_rst(cell_hold), .i_sel(i_p9_sel), .i_port_data(i_p9_data),
		.i_port_dir(i_p9_dir), .i_port_od(all_zero), .i_func_out(i_compare_only_outputs),
		.i_func_oe(all_ones), .i_float(state.emul_mode), .i_pad_in(i_p9_pad_in),
		.o_pad_out(o_p9_pad_out), .o_pad_oe(o_p9_pad_oe), .o_pad_in_sync(o_p9_in)
	);

	ppfm_port_cell #(.W(`PPFM_W6)) u_p10 (
		.i_clk(i_clk), .i_rst(cell_hold), .i_sel(i_p10_sel), .i_port_data(i_p10_data),
		.i_port_dir(i_p10_dir), .i_port_od(zero6), .i_func_out(p10_func),
		.i_func_oe(p10_func_oe), .i_float(state.emul_mode), .i_pad_in(i_p10_pad_in),
		.o_pad_out(o_p10_pad_out), .o_pad_oe(o_p10_pad_oe), .o_pad_in_sync(o_p10_in)
	);
	assign o_sync_serial0_clock = o_p10_in[`PPFM_P10_SC0];
	assign o_sync_serial0_data = o_p10_in[`PPFM_P10_SD0];
	assign o_sync_serial1_clock = o_p10_in[`PPFM_P10_SC1];
	assign o_sync_serial1_data = o_p10_in[`PPFM_P10_SD1];
	assign o_capture_compare_ch16 = o_p10_in[`PPFM_P10_CC16];
endmodule
`default_nettype wire
